// *** rtl/sad_pkg.sv ***
package sad_pkg;

  // bus widths
  localparam int AW = 32;
  localparam int DW = 32;

  // top address byte boundaries of the system map
  localparam logic [7:0] TOP_DTCM = 8'h04;
  localparam logic [7:0] TOP_TCM_END = 8'h08;
  localparam logic [7:0] TOP_SDRAM_LO_END = 8'h10;
  localparam logic [7:0] TOP_CMREG = 8'h10;
  localparam logic [7:0] TOP_PERIPH_LO = 8'h11;
  localparam logic [7:0] TOP_PERIPH_HI = 8'h1f;
  localparam logic [7:0] TOP_BOOT_LO = 8'h20;
  localparam logic [7:0] TOP_FLASH = 8'h24;
  localparam logic [7:0] TOP_FLASH_32 = 8'h25;
  localparam logic [7:0] TOP_FLASH_64 = 8'h26;
  localparam logic [7:0] TOP_FLASH_END = 8'h28;
  localparam logic [3:0] NIB_SDRAM_HI = 4'h8;
  localparam logic [3:0] NIB_APB = 4'hc;
  localparam logic [7:0] TOP_LOGIC = 8'hd0;
  localparam int SSRAM_SEL_BIT = 23;

  // apb peripheral slots inside the 0xc0 region, by address bits 27:24
  localparam logic [3:0] APB_LCD = 4'h0;
  localparam logic [3:0] APB_ETH = 4'h8;
  localparam logic [3:0] APB_GPIO = 4'h9;
  localparam logic [3:0] APB_SIC = 4'ha;
  localparam logic [3:0] APB_CPREG = 4'hb;
  localparam int NUM_APB = 5;

  // physical sizes as address widths, and the boot block at top of flash
  localparam int ITCM_AW = 17;
  localparam int DTCM_AW = 17;
  localparam int SSRAM_AW = 20;
  localparam int SDRAM_AW = 28;
  localparam int BOOT_AW = 18;
  // boot block position as flash offset bits 25:18, per fitted size
  localparam logic [7:0] BOOT_TOP_16 = 8'h3f;
  localparam logic [7:0] BOOT_TOP_32 = 8'h7f;
  localparam logic [7:0] BOOT_TOP_64 = 8'hff;

  // flash capacity codes
  localparam logic [1:0] FSZ_16MB = 2'h0;
  localparam logic [1:0] FSZ_32MB = 2'h1;
  localparam logic [1:0] FSZ_64MB = 2'h2;

  // wait states
  localparam int WSW = 5;
  localparam logic [WSW-1:0] WS_SSRAM = 5'h00;
  localparam logic [WSW-1:0] WS_TCM = 5'h00;
  localparam logic [WSW-1:0] WS_FLASH = 5'h06;
  localparam logic [WSW-1:0] WS_SDRAM_MAX = 5'h1f;
  localparam logic [WSW-1:0] WS_LIMIT = 5'h1f;

  // reset values
  localparam logic [4:0] CFG_RST = 5'h00;

  // slave targets; the default slave never gets a select line
  typedef enum logic [3:0] {
    SAD_T_ITCM = 4'h0,
    SAD_T_DTCM = 4'h1,
    SAD_T_SDRAM = 4'h2,
    SAD_T_CMREG = 4'h3,
    SAD_T_SSRAM = 4'h4,
    SAD_T_PERIPH = 4'h5,
    SAD_T_FLASH = 4'h6,
    SAD_T_LOGIC = 4'h7,
    SAD_T_APB = 4'h8,
    SAD_T_DFLT = 4'h9
  } sad_tgt_t;
  localparam int NUM_SLV = 9;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic write;
    logic [DW-1:0] wdata;
  } sad_req_t;

  typedef struct packed {
    logic err;
    logic [DW-1:0] rdata;
  } sad_rsp_t;

  typedef struct packed {
    logic tcm_en;
    logic [1:0] module_id;
    logic [1:0] flash_size;
  } sad_cfg_t;

endpackage

// *** rtl/sad_wait_timer.sv ***
// down counter that measures out the wait states of one access
module sad_wait_timer #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load,
  // status
  output logic expired
);

  logic [W-1:0] cnt_q;
  logic act_q;

  // load on start, count down to zero, hold there until stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      act_q <= 1'b1;
    end else if (stop) begin
      act_q <= 1'b0;
    end else if (act_q && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign expired = act_q && (cnt_q == '0);

endmodule

// *** rtl/sad_decoder.sv ***
// Functional notes
// [R1] with tcm on, 0x00000000-0x03ffffff selects the itcm, 128KB aliased.
// [R2] with tcm on, 0x04000000-0x07ffffff selects the dtcm, aliased.
// [R3] 0x10800000-0x10ffffff selects the ssram, aliased to fill 8MB.
// [R4] 0x28000000-0x7fffffff and 0x90000000-0xbfffffff end in an abort.
// [R5] 0x24000000-0x24ffffff selects the baseboard flash.
// [R6] 0x25000000-0x27ffffff reaches flash only when larger flash is fitted.
// [R7] 0xd0000000-0xffffffff is forwarded to the logic modules.
// [R8] 0xc0000000-0xcfffffff selects control registers and apb peripherals.
// [R9] the top 256KB of flash holds boot code and is kept free of user code.
// [R10] ssram has 0 wait states, sdram 0 to 31, flash 6.
// [R11] high-speed selects come from the address and the stack module id.
// [R12] a default slave answers every address no other slave claims.
// [R13] a read mux returns the read data of the selected slave.
// [R14] each apb peripheral gets its own select line.
// [R15] every address selects exactly one slave, real or default.
module sad_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // board straps, asynchronous to clock
  input wire logic tcm_en,
  input wire logic [1:0] module_id,
  input wire logic [1:0] flash_size,
  // master request
  input wire logic m_valid,
  input wire sad_pkg::sad_req_t m_req,
  output logic m_ready,
  // master response
  output logic m_rvalid,
  output sad_pkg::sad_rsp_t m_rsp,
  // high-speed slaves
  output logic [sad_pkg::NUM_SLV-1:0] s_sel,
  output sad_pkg::sad_req_t s_req,
  input wire logic [sad_pkg::NUM_SLV-1:0] s_done,
  input wire logic [sad_pkg::NUM_SLV-1:0][sad_pkg::DW-1:0] s_rdata,
  // apb peripheral selects
  output logic [sad_pkg::NUM_APB-1:0] psel,
  output logic penable
);

  typedef enum logic [0:0] {
    SAD_ST_IDLE = 1'b0,
    SAD_ST_BUSY = 1'b1
  } sad_st_t;

  // keep only the low address bits of an aliased memory
  function automatic logic [sad_pkg::AW-1:0] sad_alias(
    input logic [sad_pkg::AW-1:0] a,
    input int aw
  );
    sad_alias = a & ~(32'hffffffff << aw);
  endfunction

  // strap synchroniser and settled copy
  sad_pkg::sad_cfg_t cfg_s1_q, cfg_s2_q, cfg_s3_q, cfg_q;
  sad_pkg::sad_cfg_t cfg_raw;

  // sequencing state
  sad_st_t st_q, st_d;
  sad_pkg::sad_tgt_t tgt_q;
  logic hs_q;
  logic m_ready_q, m_rvalid_q, penable_q;
  sad_pkg::sad_rsp_t rsp_q;
  logic [sad_pkg::NUM_SLV-1:0] sel_q;
  sad_pkg::sad_req_t sreq_q;
  logic [sad_pkg::NUM_APB-1:0] psel_q;

  // decode wires
  logic [7:0] a_top;
  logic [3:0] a_nib;
  logic tcm_on;
  logic hit_itcm, hit_dtcm, hit_sdram_lo, hit_sdram_hi, hit_sdram;
  logic hit_cmreg, hit_ssram, hit_periph, hit_boot, hit_flash;
  logic hit_flash_ext, hit_logic, hit_apb_rgn, hit_apb;
  logic [sad_pkg::NUM_APB-1:0] psel_d;
  sad_pkg::sad_tgt_t tgt_d;
  logic [sad_pkg::AW-1:0] fwd_addr;
  logic [7:0] flash_top;
  logic [sad_pkg::WSW-1:0] ws_d;
  logic hs_d;

  // handshake wires
  logic take, tmr_exp, done_raw, finish, timeout;
  logic [sad_pkg::DW-1:0] rdata_mux;

  // bring the straps in with three flops, accept once two agree
  assign cfg_raw = '{tcm_en: tcm_en, module_id: module_id,
                     flash_size: flash_size};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_q <= sad_pkg::CFG_RST;
      cfg_s2_q <= sad_pkg::CFG_RST;
      cfg_s3_q <= sad_pkg::CFG_RST;
      cfg_q <= sad_pkg::CFG_RST;
    end else begin
      cfg_s1_q <= cfg_raw;
      cfg_s2_q <= cfg_s1_q;
      cfg_s3_q <= cfg_s2_q;
      if (cfg_s2_q == cfg_s3_q) begin
        cfg_q <= cfg_s3_q;
      end
    end
  end

  // region hits from the top address byte
  assign a_top = m_req.addr[31:24];
  assign a_nib = m_req.addr[27:24];
  // straps read as zero until settled: tcm off, id 0, smallest flash
  assign tcm_on = cfg_q.tcm_en;
  assign hit_itcm = tcm_on && a_top < sad_pkg::TOP_DTCM; // [R1]
  assign hit_dtcm = tcm_on && a_top >= sad_pkg::TOP_DTCM
                    && a_top < sad_pkg::TOP_TCM_END; // [R2]
  assign hit_sdram_lo = a_top < sad_pkg::TOP_SDRAM_LO_END
                        && !hit_itcm && !hit_dtcm;
  // only this module's slice of the 0x8 region belongs to its sdram
  assign hit_sdram_hi = a_top[7:4] == sad_pkg::NIB_SDRAM_HI
                        && a_top[3:2] == cfg_q.module_id; // [R11]
  assign hit_sdram = hit_sdram_lo || hit_sdram_hi;
  assign hit_cmreg = a_top == sad_pkg::TOP_CMREG
                     && !m_req.addr[sad_pkg::SSRAM_SEL_BIT];
  assign hit_ssram = a_top == sad_pkg::TOP_CMREG
                     && m_req.addr[sad_pkg::SSRAM_SEL_BIT]; // [R3]
  assign hit_periph = a_top >= sad_pkg::TOP_PERIPH_LO
                      && a_top <= sad_pkg::TOP_PERIPH_HI;
  assign hit_boot = a_top >= sad_pkg::TOP_BOOT_LO
                    && a_top < sad_pkg::TOP_FLASH;
  // upper flash span is claimed only by fitted capacity
  assign hit_flash_ext =
    (a_top == sad_pkg::TOP_FLASH_32
     && cfg_q.flash_size != sad_pkg::FSZ_16MB)
    || (a_top >= sad_pkg::TOP_FLASH_64 && a_top < sad_pkg::TOP_FLASH_END
        && cfg_q.flash_size == sad_pkg::FSZ_64MB); // [R6]
  assign hit_flash = a_top == sad_pkg::TOP_FLASH
                     || hit_flash_ext || hit_boot; // [R5]
  assign hit_logic = a_top >= sad_pkg::TOP_LOGIC; // [R7]
  assign hit_apb_rgn = a_top[7:4] == sad_pkg::NIB_APB; // [R8]

  // one select per apb peripheral, gaps in the region stay unclaimed
  assign psel_d = hit_apb_rgn ? {a_nib == sad_pkg::APB_CPREG,
                                 a_nib == sad_pkg::APB_SIC,
                                 a_nib == sad_pkg::APB_GPIO,
                                 a_nib == sad_pkg::APB_ETH,
                                 a_nib == sad_pkg::APB_LCD}
                              : '0; // [R14]
  assign hit_apb = |psel_d;

  // one target per address; anything unclaimed is the default slave
  assign tgt_d = hit_itcm ? sad_pkg::SAD_T_ITCM :
                 hit_dtcm ? sad_pkg::SAD_T_DTCM :
                 hit_sdram ? sad_pkg::SAD_T_SDRAM :
                 hit_cmreg ? sad_pkg::SAD_T_CMREG :
                 hit_ssram ? sad_pkg::SAD_T_SSRAM :
                 hit_periph ? sad_pkg::SAD_T_PERIPH :
                 hit_flash ? sad_pkg::SAD_T_FLASH :
                 hit_logic ? sad_pkg::SAD_T_LOGIC :
                 hit_apb ? sad_pkg::SAD_T_APB :
                 sad_pkg::SAD_T_DFLT; // [R4] [R12] [R15]

  // boot alias points at the boot block on top of the fitted flash
  assign flash_top =
    cfg_q.flash_size == sad_pkg::FSZ_64MB ? sad_pkg::BOOT_TOP_64 :
    cfg_q.flash_size == sad_pkg::FSZ_32MB ? sad_pkg::BOOT_TOP_32 :
    sad_pkg::BOOT_TOP_16; // [R9]

  // slave-side address, folded for every aliased memory
  always_comb begin
    fwd_addr = m_req.addr;
    unique case (tgt_d)
      sad_pkg::SAD_T_ITCM:
        fwd_addr = sad_alias(m_req.addr, sad_pkg::ITCM_AW); // [R1]
      sad_pkg::SAD_T_DTCM:
        fwd_addr = sad_alias(m_req.addr, sad_pkg::DTCM_AW); // [R2]
      sad_pkg::SAD_T_SSRAM:
        fwd_addr = sad_alias(m_req.addr, sad_pkg::SSRAM_AW); // [R3]
      sad_pkg::SAD_T_SDRAM:
        fwd_addr = sad_alias(m_req.addr, sad_pkg::SDRAM_AW);
      sad_pkg::SAD_T_FLASH:
        fwd_addr = hit_boot
          ? {6'h00, flash_top, m_req.addr[sad_pkg::BOOT_AW-1:0]}
          : {6'h00, m_req.addr[25:0]}; // [R5]
      default:
        fwd_addr = m_req.addr;
    endcase
  end

  // wait states: fixed counts, or a bounded wait for the slave's done
  assign ws_d = tgt_d == sad_pkg::SAD_T_FLASH ? sad_pkg::WS_FLASH :
                tgt_d == sad_pkg::SAD_T_SSRAM ? sad_pkg::WS_SSRAM :
                (tgt_d == sad_pkg::SAD_T_ITCM
                 || tgt_d == sad_pkg::SAD_T_DTCM) ? sad_pkg::WS_TCM :
                tgt_d == sad_pkg::SAD_T_SDRAM ? sad_pkg::WS_SDRAM_MAX :
                sad_pkg::WS_LIMIT; // [R10]
  // handshake targets wait for done, fixed ones only for the count
  assign hs_d = !(tgt_d == sad_pkg::SAD_T_FLASH
                  || tgt_d == sad_pkg::SAD_T_SSRAM
                  || tgt_d == sad_pkg::SAD_T_ITCM
                  || tgt_d == sad_pkg::SAD_T_DTCM);

  // request accepted; the default slave answers at once
  assign take = m_valid && m_ready_q && st_q == SAD_ST_IDLE;

  sad_wait_timer #(
    .W(sad_pkg::WSW)
  ) u_wait (
    .clock(clock),
    .rst_n(rst_n),
    .start(take && tgt_d != sad_pkg::SAD_T_DFLT),
    .stop(finish || timeout),
    .load(ws_d),
    .expired(tmr_exp)
  );

  // completion: apb done counts only in its enable phase
  assign done_raw = s_done[tgt_q] && (tgt_q != sad_pkg::SAD_T_APB
                                      || penable_q);
  assign finish = st_q == SAD_ST_BUSY && (hs_q ? done_raw : tmr_exp); // [R10]
  // a done that arrives with the last count still wins over the abort
  assign timeout = st_q == SAD_ST_BUSY && hs_q && tmr_exp && !done_raw;
  assign rdata_mux = s_rdata[tgt_q]; // [R13]

  // next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SAD_ST_IDLE: begin
        if (take && tgt_d != sad_pkg::SAD_T_DFLT) begin
          st_d = SAD_ST_BUSY;
        end
      end
      SAD_ST_BUSY: begin
        if (finish || timeout) begin
          st_d = SAD_ST_IDLE;
        end
      end
    endcase
  end

  // state, target and master handshake
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SAD_ST_IDLE;
      tgt_q <= sad_pkg::SAD_T_DFLT;
      hs_q <= 1'b0;
      m_ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (take) begin
        tgt_q <= tgt_d;
        hs_q <= hs_d;
      end
      m_ready_q <= st_d == SAD_ST_IDLE;
    end
  end

  // response: abort from the default slave or timeout, else mux data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m_rvalid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      m_rvalid_q <= (take && tgt_d == sad_pkg::SAD_T_DFLT)
                    || finish || timeout;
      if (take && tgt_d == sad_pkg::SAD_T_DFLT) begin
        rsp_q <= '{err: 1'b1, rdata: '0}; // [R4] [R12]
      end else if (finish || timeout) begin
        rsp_q <= '{err: timeout, rdata: timeout ? '0 : rdata_mux}; // [R13]
      end
    end
  end

  // selects stay up from acceptance to completion, one hot at most
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= '0;
      psel_q <= '0;
      penable_q <= 1'b0;
      sreq_q <= '0;
    end else if (take && tgt_d != sad_pkg::SAD_T_DFLT) begin
      sel_q <= sad_pkg::NUM_SLV'(1) << tgt_d; // [R11] [R15]
      psel_q <= psel_d; // [R14]
      // slave sees the folded address, held until completion
      sreq_q <= '{addr: fwd_addr, write: m_req.write,
                  wdata: m_req.wdata};
    end else if (finish || timeout) begin
      sel_q <= '0;
      psel_q <= '0;
      penable_q <= 1'b0;
    end else if (|psel_q) begin
      penable_q <= 1'b1;
    end
  end

  // outputs from flops
  assign m_ready = m_ready_q;
  assign m_rvalid = m_rvalid_q;
  assign m_rsp = rsp_q;
  assign s_sel = sel_q;
  assign s_req = sreq_q;
  assign psel = psel_q;
  assign penable = penable_q;

endmodule

// *** testbench/sad_decoder_checker.sv ***
module sad_decoder_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // master side
  input wire logic m_valid,
  input wire sad_pkg::sad_req_t m_req,
  input wire logic m_ready,
  input wire logic m_rvalid,
  input wire sad_pkg::sad_rsp_t m_rsp,
  // slave side
  input wire logic [sad_pkg::NUM_SLV-1:0] s_sel,
  input wire logic [sad_pkg::NUM_SLV-1:0] s_done,
  input wire logic [sad_pkg::NUM_SLV-1:0][sad_pkg::DW-1:0] s_rdata,
  input wire logic [sad_pkg::NUM_APB-1:0] psel
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // request taken this edge, and its top address byte
  wire logic take = m_valid && m_ready;
  wire logic [7:0] top = m_req.addr[31:24];

  a_one_select: assert property ($onehot0(s_sel))
    else $error("more than one slave selected");
  a_abort_err: assert property (
    take && (top inside {[8'h28:8'h7f], [8'h90:8'hbf]})
    |=> m_rvalid && m_rsp.err && s_sel == '0)
    else $error("reserved access not aborted");
  a_flash_wait: assert property (
    take && top == 8'h24 |=> s_sel[6] [*7] ##1 m_rvalid)
    else $error("flash read not eight cycles");
  a_ssram_wait: assert property (
    take && m_req.addr[31:23] == 9'h021 |=> s_sel[4] ##1 m_rvalid)
    else $error("ssram access not zero wait");
  a_logic_sel: assert property (
    take && top >= 8'hd0 |=> s_sel[7])
    else $error("logic module not selected");
  a_apb_sel: assert property (
    take && top == 8'hc0 |=> s_sel[8] && psel == 5'h01)
    else $error("apb slot zero not selected");
  a_done_resp: assert property (
    s_sel[7] && s_done[7]
    |=> m_rvalid && s_sel == '0 && m_rsp.rdata == $past(s_rdata[7]))
    else $error("read data not returned");
  a_psel_apb: assert property (
    psel != '0 |-> s_sel[8] && $onehot(psel))
    else $error("apb select without bridge");

  // main scenarios
  c_flash: cover property (take && top == 8'h24);
  c_apb_done: cover property (s_sel[8] && s_done[8]);
  c_abort: cover property (m_rvalid && m_rsp.err);
endmodule

// *** testbench/sad_slave_model.sv ***
module sad_slave_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // decoder side
  input wire logic [sad_pkg::NUM_SLV-1:0] s_sel,
  input wire sad_pkg::sad_req_t s_req,
  input wire logic penable,
  output logic [sad_pkg::NUM_SLV-1:0] s_done,
  output logic [sad_pkg::NUM_SLV-1:0][sad_pkg::DW-1:0] s_rdata,
  // busy cycles before answering, 8'hff never answers
  input wire logic [7:0] lat
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt_q;
  logic [31:0] junk_q;

  // count busy cycles; idle data changes every cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      junk_q <= 32'h0;
    end else begin
      cnt_q <= (s_sel != '0 && s_done == '0) ? cnt_q + 8'h01 : 8'h00;
      junk_q <= junk_q + 32'h9e3779b9;
    end
  end

  // answer once lat reached; apb waits for its enable phase
  assign s_done = (cnt_q >= lat) ? (s_sel & {penable, 8'hff}) : '0;
  for (genvar t = 0; t < sad_pkg::NUM_SLV; t++) begin : g_rd
    assign s_rdata[t] = s_sel[t] ? (s_req.addr ^ 32'h5a5a0000) : junk_q;
  end
endmodule

// *** testbench/system_address_decoder_tb_top.sv ***
module system_address_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tcm_en = 1'b1;
  logic [1:0] module_id = 2'h1;
  logic [1:0] flash_size = sad_pkg::FSZ_16MB;
  logic m_valid = 1'b0;
  sad_pkg::sad_req_t m_req = '0;
  logic [7:0] lat = 8'h01;
  logic m_ready, m_rvalid, penable;
  sad_pkg::sad_rsp_t m_rsp, rsp_c;
  sad_pkg::sad_req_t s_req, req_c;
  logic [8:0] s_sel, s_done, sel_c;
  logic [8:0][31:0] s_rdata;
  logic [4:0] psel, psel_c;
  logic rdy_c, pen_c;
  int n_c, err_total, tests_run, cyc;
  logic [31:0] ta[23] = '{32'h0, 32'h03fe0010, 32'h04000000, 32'h07fffff0,
    32'h10000000, 32'h10800000, 32'h10fffffc, 32'h11000000, 32'h1fff0000,
    32'h24000000, 32'h20000000, 32'h84000000, 32'hc0000000, 32'hd0000000,
    32'hfffffffc, 32'h25000000, 32'h28000000, 32'h7ffffffc, 32'h80000000,
    32'h90000000, 32'hbffffffc, 32'hc1000000, 32'hcc000000};
  logic [8:0] ts[23] = '{9'h001, 9'h001, 9'h002, 9'h002, 9'h008, 9'h010,
    9'h010, 9'h020, 9'h020, 9'h040, 9'h040, 9'h004, 9'h100, 9'h080,
    9'h080, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0};
  logic [3:0] slot[5] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb};

  sad_decoder uut (.clock, .rst_n, .tcm_en, .module_id, .flash_size,
    .m_valid, .m_req, .m_ready, .m_rvalid, .m_rsp, .s_sel, .s_req,
    .s_done, .s_rdata, .psel, .penable);
  sad_slave_model slv (.clock, .rst_n, .s_sel, .s_req, .penable, .s_done,
    .s_rdata, .lat);

  // clock and hang guard
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // one transfer: hold until taken, note selects, count to response
  task automatic xfer(input logic [31:0] a, input logic w);
    int k;
    m_req = '{addr: a, write: w, wdata: ~a};
    m_valid = 1'b1;
    k = 0;
    while (m_ready !== 1'b1 && k < 40) begin
      idle(1);
      k++;
    end
    idle(1);
    m_valid = 1'b0;
    sel_c = s_sel;
    psel_c = psel;
    req_c = s_req;
    rdy_c = m_ready;
    pen_c = penable;
    n_c = 1;
    while (m_rvalid !== 1'b1 && n_c < 40) begin
      idle(1);
      n_c++;
    end
    rsp_c = m_rsp;
    idle(1); // an edge passes before the next request is raised
  endtask

  function automatic int lat_of(input logic [8:0] s);
    if (s == 9'h0) return 1;
    if (s == 9'h040) return 8;
    if ((s & 9'h013) != 9'h0) return 2;
    return 3;
  endfunction

  task automatic t_map();
    for (int i = 0; i < 23; i++) begin
      xfer(ta[i], 1'b0);
      chk("select", sel_c, ts[i]);
      chk("latency", n_c, lat_of(ts[i]));
      chk("abort", rsp_c.err, ts[i] == 9'h0);
      chk("ready", rdy_c, ts[i] == 9'h0);
    end
    $display("t_map done");
  endtask

  task automatic t_flash();
    flash_size = sad_pkg::FSZ_32MB;
    idle(8);
    xfer(32'h25000000, 1'b0);
    chk("flash32", sel_c, 9'h040);
    xfer(32'h26000000, 1'b0);
    chk("flash32 gap", rsp_c.err, 1'b1);
    xfer(32'h20001000, 1'b0);
    chk("boot offset", req_c.addr[25:0], 26'h1fc1000);
    flash_size = sad_pkg::FSZ_64MB;
    idle(8);
    xfer(32'h27000000, 1'b0);
    chk("flash64", sel_c, 9'h040);
    xfer(32'h20001000, 1'b0);
    chk("boot64 offset", req_c.addr[25:0], 26'h3fc1000);
    flash_size = sad_pkg::FSZ_16MB;
    idle(8);
    $display("t_flash done");
  endtask

  task automatic t_hand();
    lat = 8'h04;
    xfer(32'hd0000100, 1'b1);
    chk("slow latency", n_c, 6);
    chk("write fwd", req_c.write, 1'b1);
    chk("wdata fwd", req_c.wdata, 32'h2ffffeff);
    chk("rdata", rsp_c.rdata, 32'h8a5a0100);
    lat = 8'hff;
    xfer(32'h11000000, 1'b0);
    chk("timeout err", rsp_c.err, 1'b1);
    chk("timeout data", rsp_c.rdata, 32'h0);
    chk("timeout len", n_c, 33);
    lat = 8'h01;
    $display("t_hand done");
  endtask

  task automatic t_alias();
    xfer(32'h03fe0010, 1'b1);
    chk("itcm fold", req_c.addr, 32'h00000010);
    xfer(32'h07fe0014, 1'b0);
    chk("dtcm fold", req_c.addr, 32'h00000014);
    xfer(32'h10f00020, 1'b0);
    chk("ssram sel", sel_c, 9'h010);
    chk("ssram fold", req_c.addr, 32'h00000020);
    xfer(32'h24123450, 1'b0);
    chk("flash offset", req_c.addr, 32'h00123450);
    $display("t_alias done");
  endtask

  task automatic t_apb();
    for (int i = 0; i < 5; i++) begin
      xfer({4'hc, slot[i], 24'h000010}, 1'b0);
      chk("apb select", psel_c, 5'h01 << i);
      chk("apb setup", pen_c, 1'b0);
      chk("apb bridge", sel_c, 9'h100);
    end
    $display("t_apb done");
  endtask

  task automatic t_straps();
    tcm_en = 1'b0;
    module_id = 2'h2;
    idle(8);
    xfer(32'h00000000, 1'b0);
    chk("tcm off low", sel_c, 9'h004);
    xfer(32'h04000000, 1'b0);
    chk("tcm off dtcm", sel_c, 9'h004);
    xfer(32'h88000000, 1'b0);
    chk("own slice", sel_c, 9'h004);
    xfer(32'h84000000, 1'b0);
    chk("other slice", rsp_c.err, 1'b1);
    tcm_en = 1'b1;
    module_id = 2'h1;
    idle(8);
    $display("t_straps done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    idle(8);
    t_map();
    t_alias();
    t_flash();
    t_hand();
    t_apb();
    t_straps();
    finish_test();
  end
endmodule

bind sad_decoder sad_decoder_checker chk_i (.clock, .rst_n, .m_valid,
  .m_req, .m_ready, .m_rvalid, .m_rsp, .s_sel, .s_done, .s_rdata, .psel);
